// [apr_router.sv]
// Alarm pin routing, polarity, clock-select pin control and signal-loss interrupt masking.
`include "apr_cfg.svh"
module apr_router (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register access port
    input wire apr_pkg::apr_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // Alarm conditions from the device core
    input wire logic input_one_bad_status_i,
    input wire logic input_two_bad_status_i,
    input wire logic lock_loss_status_i,
    input wire logic input_one_active_status_i,
    input wire apr_pkg::apr_flags_t alarm_event_i,
    // Clock selection
    input wire logic [1:0] auto_select_mode_i,
    input wire logic [1:0] register_clock_select_i,
    output logic [1:0] selected_clock_o,
    output logic pin_select_active_o,
    // Status pins
    input wire logic select_active_pin_i,
    output apr_pkg::apr_pins_t pin_out_o,
    output apr_pkg::apr_pins_t pin_oe_n_o,
    // Status
    output logic interrupt_status_o,
    output apr_pkg::apr_flags_t flags_o
);

    localparam logic [7:0] PIN_EN_RST = `APR_PIN_EN_RST;
    localparam logic [7:0] SEL_CTL_RST = `APR_SEL_CTL_RST;
    localparam logic [7:0] POL_RST = `APR_POL_RST;
    localparam logic [7:0] LOS_MSK_RST = `APR_LOS_MSK_RST;
    localparam logic [7:0] LOCK_LOSS_MASK_RST = `APR_LOCK_LOSS_MASK_RST;

    logic [3:0] pin_en_r;
    logic [1:0] sel_ctl_r;
    logic [3:0] pol_r;
    logic [2:0] los_msk_r;
    logic lock_loss_mask_r;
    apr_pkg::apr_flags_t flags_r;
    apr_pkg::apr_flags_t flags_nxt;
    apr_pkg::apr_pins_t pins_nxt;
    apr_pkg::apr_pins_t oe_n_nxt;
    logic [7:0] rdata_nxt;
    logic irq_nxt;
    logic [1:0] sel_nxt;
    logic armed_r;
    logic ca_level;

    // Address decode.
    wire hit_pin_en = reg_req_i.addr == `APR_PIN_EN_OFFS;
    wire hit_sel_ctl = reg_req_i.addr == `APR_SEL_CTL_OFFS;
    wire hit_pol = reg_req_i.addr == `APR_POL_OFFS;
    wire hit_los_msk = reg_req_i.addr == `APR_LOS_MSK_OFFS;
    wire hit_lock_loss_mask = reg_req_i.addr == `APR_LOCK_LOSS_MASK_OFFS;
    wire hit_flag = reg_req_i.addr == `APR_FLAG_OFFS;
    wire wr_pin_en = reg_req_i.wr && hit_pin_en;
    wire wr_sel_ctl = reg_req_i.wr && hit_sel_ctl;
    wire wr_pol = reg_req_i.wr && hit_pol;
    wire wr_los_msk = reg_req_i.wr && hit_los_msk;
    wire wr_lock_loss_mask = reg_req_i.wr && hit_lock_loss_mask;
    wire wr_flag = reg_req_i.wr && hit_flag;

    // Read mux; reserved bits read as their reset pattern.
    assign rdata_nxt = hit_pin_en ? {PIN_EN_RST[7:4], pin_en_r} :
                       hit_sel_ctl ? {SEL_CTL_RST[7:2], sel_ctl_r} :
                       hit_pol ? {POL_RST[7:4], pol_r} :
                       hit_los_msk ? {5'h00, los_msk_r} :
                       hit_lock_loss_mask ? {LOCK_LOSS_MASK_RST[7:1], lock_loss_mask_r} :
                       hit_flag ? {4'h0, flags_r} :
                       `APR_UNMAPPED_RD;

    // Clock selection from the pin is possible only in manual mode.
    wire manual_mode = auto_select_mode_i == `APR_MANUAL_SEL;
    wire pin_ctl = manual_mode && sel_ctl_r[`APR_SEL_PIN_BIT];
    wire pin_level;

    apr_pin_sync #(
        .STAGES(`APR_SYNC_STAGES)
    ) u_cs_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(select_active_pin_i),
        .level_o(pin_level)
    );

    // Pin low picks input clock one, pin high input clock two.
    assign sel_nxt = pin_ctl ? {1'b0, pin_level} : register_clock_select_i;

    // Flags: a new event wins over a clear in the same cycle.
    assign flags_nxt = (flags_r & ~(wr_flag ? reg_req_i.wdata[3:0] : 4'h0)) | alarm_event_i;

    wire [3:0] flag_gate = {~lock_loss_mask_r, ~los_msk_r};
    assign irq_nxt = |(flags_r & flag_gate);

    wire c1b_level = input_one_bad_status_i ~^ pol_r[`APR_BAD_POL_BIT];
    wire int_level = irq_nxt ~^ pol_r[`APR_INTERRUPT_POLARITY_BIT];
    assign ca_level = input_one_active_status_i ~^ pol_r[`APR_CA_POL_BIT];

    assign pins_nxt.c2b = input_two_bad_status_i ~^ pol_r[`APR_BAD_POL_BIT];
    assign oe_n_nxt.c2b = !pin_en_r[`APR_C2B_EN_BIT];
    assign pins_nxt.lock_loss_output = lock_loss_status_i ~^ pol_r[`APR_LOCK_LOSS_POLARITY_BIT];
    assign oe_n_nxt.lock_loss_output = !pin_en_r[`APR_LOL_EN_BIT];
    // Interrupt takes the combined pin before clock-one-bad does.
    assign pins_nxt.combined_interrupt_output = pin_en_r[`APR_INT_EN_BIT] ? int_level : c1b_level;
    assign oe_n_nxt.combined_interrupt_output = !(pin_en_r[`APR_INT_EN_BIT] || pin_en_r[`APR_C1B_EN_BIT]);
    // The select pin is an input while it steers clock selection, so it is never driven then.
    assign pins_nxt.select_active_pin = ca_level;
    assign oe_n_nxt.select_active_pin = !(sel_ctl_r[`APR_CA_EN_BIT] && !pin_ctl);

    // Configuration registers; mask writes touch only mask bits.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_en_r <= PIN_EN_RST[3:0];
            sel_ctl_r <= SEL_CTL_RST[1:0];
            pol_r <= POL_RST[3:0];
            los_msk_r <= LOS_MSK_RST[2:0];
            lock_loss_mask_r <= LOCK_LOSS_MASK_RST[0];
        end else begin
            if (wr_pin_en) begin
                pin_en_r <= reg_req_i.wdata[3:0];
            end
            if (wr_sel_ctl) begin
                sel_ctl_r <= reg_req_i.wdata[1:0];
            end
            if (wr_pol) begin
                pol_r <= reg_req_i.wdata[3:0];
            end
            if (wr_los_msk) begin
                los_msk_r <= reg_req_i.wdata[2:0];
            end
            if (wr_lock_loss_mask) begin
                lock_loss_mask_r <= reg_req_i.wdata[`APR_LOCK_LOSS_MASK_BIT];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Registered outputs; all pins float during reset.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_out_o <= '0;
            pin_oe_n_o <= '1;
            interrupt_status_o <= 1'b0;
            selected_clock_o <= 2'h0;
            pin_select_active_o <= 1'b0;
        end else begin
            pin_out_o <= pins_nxt;
            pin_oe_n_o <= oe_n_nxt;
            interrupt_status_o <= irq_nxt;
            selected_clock_o <= sel_nxt;
            pin_select_active_o <= pin_ctl;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    assign flags_o = flags_r;

    // Marks cycles whose registered outputs were computed outside reset.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= 1'b1;
        end
    end

    // Checks compare registered outputs with their sources one cycle earlier.
    // The armed_r term keeps those that carry it quiet until the outputs hold a value computed outside reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_C2B_ON: assert property (
        armed_r && $past(pin_en_r[3]) |->
            !pin_oe_n_o.c2b && (pin_out_o.c2b == ($past(input_two_bad_status_i) ~^ $past(pol_r[2])))
    ) else $error("clock-two-bad pin not showing status");

    AST_C2B_OFF: assert property (
        armed_r && !$past(pin_en_r[3]) |-> pin_oe_n_o.c2b
    ) else $error("clock-two-bad pin driven while disabled");

    AST_LOCK_LOSS_PIN_ENABLE: assert property (
        armed_r |-> (pin_oe_n_o.lock_loss_output == !$past(pin_en_r[1]))
            && (pin_out_o.lock_loss_output == ($past(lock_loss_status_i) ~^ $past(pol_r[1])))
    ) else $error("lock-loss pin wrong");

    AST_INT_PIN: assert property (
        armed_r && $past(pin_en_r[0]) |->
            !pin_oe_n_o.combined_interrupt_output && (pin_out_o.combined_interrupt_output == (interrupt_status_o ~^ $past(pol_r[0])))
    ) else $error("combined pin not showing interrupt");

    AST_INT_OFF: assert property (
        armed_r && !$past(pin_en_r[0]) && !$past(pin_en_r[2]) |-> pin_oe_n_o.combined_interrupt_output
    ) else $error("combined pin driven while both enables clear");

    AST_C1B_ON_INT: assert property (
        armed_r && !$past(pin_en_r[0]) && $past(pin_en_r[2]) |->
            !pin_oe_n_o.combined_interrupt_output
            && (pin_out_o.combined_interrupt_output == ($past(input_one_bad_status_i) ~^ $past(pol_r[2])))
    ) else $error("combined pin not showing clock-one bad");

    AST_CA_PIN: assert property (
        armed_r && $past(sel_ctl_r[1]) && !pin_select_active_o |->
            !pin_oe_n_o.select_active_pin
            && (pin_out_o.select_active_pin == ($past(input_one_active_status_i) ~^ $past(pol_r[3])))
    ) else $error("select pin not showing clock-active status");

    AST_CA_LOCKED: assert property (
        armed_r && pin_select_active_o |-> pin_oe_n_o.select_active_pin
    ) else $error("select pin driven while it selects the clock");

    AST_SEL_PIN: assert property (
        armed_r && $past(manual_mode) && $past(sel_ctl_r[0]) |->
            pin_select_active_o && (selected_clock_o == {1'b0, $past(pin_level)})
    ) else $error("pin selection not followed");

    AST_SEL_AUTO: assert property (
        armed_r && !$past(manual_mode) |->
            !pin_select_active_o && (selected_clock_o == $past(register_clock_select_i))
    ) else $error("select-by-pin acted outside manual mode");

    AST_MASK_KEEP: assert property (
        (wr_los_msk || wr_lock_loss_mask) && (alarm_event_i == 4'h0) |=> flags_r == $past(flags_r)
    ) else $error("mask write changed a flag");

    AST_FLAG_SET: assert property (
        alarm_event_i.los2 |=> flags_r.los2 ##1 (interrupt_status_o || $past(los_msk_r[2]))
    ) else $error("input-two signal loss not latched or not raised");

    AST_LOS1_IRQ: assert property (
        armed_r && $past(flags_r.los1) && !$past(los_msk_r[1]) |-> interrupt_status_o
    ) else $error("unmasked input-one signal loss missing from interrupt");

    AST_LOSX_IRQ: assert property (
        armed_r && $past(flags_r.losx) && !$past(los_msk_r[0]) |-> interrupt_status_o
    ) else $error("unmasked reference signal loss missing from interrupt");

    AST_LOL_IRQ: assert property (
        armed_r && $past(flags_r.lock_loss_output) && !$past(lock_loss_mask_r) |-> interrupt_status_o
    ) else $error("unmasked lock-loss flag missing from interrupt");

    AST_IRQ_QUIET: assert property (
        armed_r && (($past(flags_r) & $past(flag_gate)) == 4'h0) |-> !interrupt_status_o
    ) else $error("interrupt raised with every flag masked or clear");

    AST_RESET_VAL: assert property (
        armed_r && !$past(armed_r) && !$past(reg_req_i.wr) |->
            (pin_en_r == 4'hE) && (pol_r == 4'hF) && (sel_ctl_r == 2'h3)
    ) else $error("configuration not at reset values");

    AST_RESET_PINS: assert property (
        armed_r && !$past(armed_r) |->
            !pin_oe_n_o.c2b && !pin_oe_n_o.combined_interrupt_output && !pin_oe_n_o.lock_loss_output
    ) else $error("enabled alarm pins not driven after reset");

    AST_CA_OFF: assert property (
        armed_r && !$past(sel_ctl_r[1]) |-> pin_oe_n_o.select_active_pin
    ) else $error("select pin driven while clock-active enable clear");

    AST_SEL_REG: assert property (
        armed_r && $past(manual_mode) && !$past(sel_ctl_r[0]) |->
            !pin_select_active_o && (selected_clock_o == $past(register_clock_select_i))
    ) else $error("register clock select not followed");

    AST_LOS2_IRQ: assert property (
        armed_r && $past(flags_r.los2) && !$past(los_msk_r[2]) |-> interrupt_status_o
    ) else $error("unmasked input-two signal loss missing from interrupt");

    AST_FLAG_HOLD: assert property (
        armed_r && $past(flags_r.los1) && !$past(wr_flag) |-> flags_r.los1
    ) else $error("latched input-one signal-loss flag dropped without a clear");

    AST_EVENT_WINS: assert property (
        armed_r && $past(alarm_event_i.lock_loss_output) |-> flags_r.lock_loss_output
    ) else $error("lock-loss event lost against a clear");

    AST_FLAG_CLEAR: assert property (
        armed_r && $past(wr_flag) && $past(reg_req_i.wdata[2]) && !$past(alarm_event_i.los2) |->
            !flags_r.los2
    ) else $error("input-two signal-loss flag not cleared");

    AST_FLAG_READ: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_flag) |-> reg_rdata_o == {4'h0, $past(flags_r)}
    ) else $error("flag read-back differs from the latched flags");

    // Reserved bits must read back their reset pattern, whatever was written to them.
    AST_RD_PIN_EN: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_pin_en) |-> reg_rdata_o[7:4] == 4'h3
    ) else $error("alarm pin enable reserved bits read wrong");

    AST_RD_POL: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_pol) |-> reg_rdata_o[7:4] == 4'hD
    ) else $error("polarity reserved bits read wrong");

    AST_RD_SEL_CTL: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_sel_ctl) |-> reg_rdata_o[7:2] == 6'h3F
    ) else $error("clock select control reserved bits read wrong");

    AST_RD_LOS_MSK: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_los_msk) |-> reg_rdata_o[7:3] == 5'h00
    ) else $error("signal-loss mask reserved bits read wrong");

    AST_RD_LOCK_LOSS_MASK: assert property (
        armed_r && $past(reg_req_i.rd) && $past(hit_lock_loss_mask) |-> reg_rdata_o[7:1] == 7'h1F
    ) else $error("lock-loss mask reserved bits read wrong");

endmodule : apr_router

// [apr_cfg.svh]
// Register offsets, bit positions, reset values and timing counts of the alarm pin router.
`ifndef APR_CFG_SVH
`define APR_CFG_SVH

`define APR_PIN_EN_OFFS 8'h14
`define APR_SEL_CTL_OFFS 8'h15
`define APR_POL_OFFS 8'h16
`define APR_LOS_MSK_OFFS 8'h17
`define APR_LOCK_LOSS_MASK_OFFS 8'h18
`define APR_FLAG_OFFS 8'h84

`define APR_PIN_EN_RST 8'h3E
`define APR_SEL_CTL_RST 8'hFF
`define APR_POL_RST 8'hDF
`define APR_LOS_MSK_RST 8'h07
`define APR_LOCK_LOSS_MASK_RST 8'h3F
`define APR_UNMAPPED_RD 8'h00

`define APR_C2B_EN_BIT 3
`define APR_C1B_EN_BIT 2
`define APR_LOL_EN_BIT 1
`define APR_INT_EN_BIT 0

`define APR_CA_EN_BIT 1
`define APR_SEL_PIN_BIT 0

`define APR_CA_POL_BIT 3
`define APR_BAD_POL_BIT 2
`define APR_LOCK_LOSS_POLARITY_BIT 1
`define APR_INTERRUPT_POLARITY_BIT 0

`define APR_INPUT_TWO_SIGNAL_LOSS_MASK_BIT 2
`define APR_INPUT_ONE_SIGNAL_LOSS_MASK_BIT 1
`define APR_REFERENCE_SIGNAL_LOSS_MASK_BIT 0
`define APR_LOCK_LOSS_MASK_BIT 0

`define APR_MANUAL_SEL 2'h0
`define APR_SYNC_STAGES 3

`endif

// [apr_pkg.sv]
// Types shared by the alarm pin router, the board model and the bench.
package apr_pkg;

    // One bit per status pin.
    typedef struct packed {
        logic c2b;
        logic combined_interrupt_output;
        logic lock_loss_output;
        logic select_active_pin;
    } apr_pins_t;

    // Latched alarm flags.
    typedef struct packed {
        logic lock_loss_output;
        logic los2;
        logic los1;
        logic losx;
    } apr_flags_t;

    // One register access, taken in a single cycle.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } apr_reg_req_t;

endpackage : apr_pkg

// [apr_pin_sync.sv]
// Three-stage synchroniser with agreement filter for an input pin.
`include "apr_cfg.svh"
module apr_pin_sync #(
    parameter int STAGES = `APR_SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);

    logic [STAGES-1:0] chain_r;

    generate
        if (STAGES < 3) begin : g_bad_stages
            $error("apr_pin_sync needs at least three stages");
        end
    endgenerate

    // The first stage is read only by the second; the filter looks at the last two.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chain_r <= '0;
            level_o <= 1'b0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], pin_i};
            if (chain_r[STAGES-1] == chain_r[STAGES-2]) begin
                level_o <= chain_r[STAGES-1];
            end
        end
    end

endmodule : apr_pin_sync

// [apr_board.sv]
// Board logic model that watches the status pins and drives the select pin.
module apr_board (
    // Clock
    input wire logic clk_i,
    // Pins from the device
    input wire apr_pkg::apr_pins_t pin_out_i,
    input wire apr_pkg::apr_pins_t pin_oe_n_i,
    // Level the board puts on the select pin
    input wire logic sel_level_i,
    output apr_pkg::apr_pins_t wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_r = 4'h0;
    logic [3:0] mix;
    // A released pin other than the select pin has no pull, so it shows the inverse of its last driven level.
    assign mix = (pin_out_i & ~pin_oe_n_i) | (~last_r & pin_oe_n_i);
    assign wire_o = {mix[3:1], pin_oe_n_i.select_active_pin ? sel_level_i : pin_out_i.select_active_pin};
    // Only a driven level is remembered, so a released pin holds one stale inverse.
    always @(posedge clk_i) begin
        last_r <= (pin_out_i & ~pin_oe_n_i) | (last_r & pin_oe_n_i);
    end
endmodule : apr_board

// [test_apr_router.sv]
// Self-checking bench for the alarm pin router.
module test_apr_router;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, one_bad, two_bad, lol_st, one_act, sel_lvl, pin_sel, irq;
    logic [7:0] rdata;
    logic [1:0] mode, reg_sel, sel_clk;
    apr_pkg::apr_reg_req_t req;
    apr_pkg::apr_flags_t ev, flags;
    apr_pkg::apr_pins_t pout, poe_n, pwire;
    int errors;
    int n_compared;

    apr_router u_dut (
        .clk_i(clk), .resetn_i(resetn), .reg_req_i(req), .reg_rdata_o(rdata),
        .input_one_bad_status_i(one_bad), .input_two_bad_status_i(two_bad),
        .lock_loss_status_i(lol_st), .input_one_active_status_i(one_act),
        .alarm_event_i(ev), .auto_select_mode_i(mode), .register_clock_select_i(reg_sel),
        .selected_clock_o(sel_clk), .pin_select_active_o(pin_sel),
        .select_active_pin_i(pwire.select_active_pin), .pin_out_o(pout), .pin_oe_n_o(poe_n),
        .interrupt_status_o(irq), .flags_o(flags)
    );
    apr_board u_board (
        .clk_i(clk), .pin_out_i(pout), .pin_oe_n_i(poe_n), .sel_level_i(sel_lvl),
        .wire_o(pwire)
    );

    task automatic conclude;
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // Config reaches the pins two cycles after the write, so the write waits three.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        req.wr = 1'b0;
        idle(3);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : rd

    task automatic t_reset;
        chk({4'h0, poe_n}, 8'h01);
        rd(8'h14, 8'h3E);
        rd(8'h15, 8'hFF);
        rd(8'h16, 8'hDF);
        rd(8'h17, 8'h07);
        rd(8'h18, 8'h3F);
        rd(8'h40, 8'h00);
    endtask : t_reset

    task automatic t_bad;
        wr(8'h14, 8'h0C);
        two_bad = 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(8'h16, p ? 8'h04 : 8'h00);
            chk({6'h0, pwire.c2b, pwire.combined_interrupt_output}, {6'h0, p[0], ~p[0]});
        end
        one_bad = 1'b1;
        idle(2);
        chk({7'h0, pwire.combined_interrupt_output}, 8'h01);
        one_bad = 1'b0;
        chk({4'h0, poe_n}, 8'h03);
        wr(8'h14, 8'h00);
        chk({4'h0, poe_n}, 8'h0F);
    endtask : t_bad

    task automatic t_lol;
        lol_st = 1'b1;
        wr(8'h14, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wr(8'h16, p ? 8'h02 : 8'h00);
            chk({7'h0, pwire.lock_loss_output}, {7'h0, p[0]});
        end
        chk({4'h0, poe_n}, 8'h0D);
    endtask : t_lol

    task automatic t_irq;
        logic [3:0] b;
        wr(8'h14, 8'h05);
        wr(8'h16, 8'h01);
        for (int i = 0; i < 4; i++) begin
            b = 4'h1 << i;
            wr(8'h17, 8'h07);
            wr(8'h18, 8'h01);
            ev = b;
            @(negedge clk);
            ev = 4'h0;
            idle(2);
            chk({4'h0, flags}, {4'h0, b});
            chk({6'h0, irq, pwire.combined_interrupt_output}, 8'h00);
            if (i < 3) begin
                wr(8'h17, 8'h07 & ~{5'h0, b[2:0]});
            end else begin
                wr(8'h18, 8'h00);
            end
            chk({6'h0, irq, pwire.combined_interrupt_output}, 8'h03);
            chk({4'h0, flags}, {4'h0, b});
            wr(8'h16, 8'h00);
            chk({7'h0, pwire.combined_interrupt_output}, 8'h00);
            wr(8'h16, 8'h01);
            wr(8'h84, {4'h0, b});
            chk({3'h0, irq, flags}, 8'h00);
        end
    endtask : t_irq

    task automatic t_select;
        reg_sel = 2'h2;
        wr(8'h15, 8'h01);
        for (int v = 0; v < 2; v++) begin
            sel_lvl = v[0];
            idle(8);
            chk({6'h0, sel_clk}, {7'h0, v[0]});
        end
        chk({6'h0, pin_sel, poe_n.select_active_pin}, 8'h03);
        wr(8'h15, 8'h00);
        chk({6'h0, sel_clk}, 8'h02);
        chk({7'h0, poe_n.select_active_pin}, 8'h01);
        mode = 2'h1;
        one_act = 1'b1;
        wr(8'h15, 8'h03);
        chk({7'h0, pin_sel}, 8'h00);
        chk({6'h0, sel_clk}, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wr(8'h16, p ? 8'h08 : 8'h00);
            chk({6'h0, poe_n.select_active_pin, pwire.select_active_pin}, {7'h0, p[0]});
        end
        mode = 2'h0;
        idle(3);
        chk({6'h0, pin_sel, poe_n.select_active_pin}, 8'h03);
    endtask : t_select

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        errors = 0;
        n_compared = 0;
        resetn = 1'b0;
        req = '0;
        one_bad = 1'b0;
        two_bad = 1'b0;
        lol_st = 1'b0;
        one_act = 1'b0;
        sel_lvl = 1'b0;
        ev = '0;
        mode = 2'h0;
        reg_sel = 2'h0;
        idle(8);
        resetn = 1'b1;
        idle(3);
        t_reset();
        t_bad();
        t_lol();
        t_irq();
        t_select();
        conclude();
    end

    // The tests need well under two thousand cycles; this span is several times that.
    initial begin
        #40000;
        errors++;
        conclude();
    end
endmodule : test_apr_router
